// file: inc/mrgc_pkg.sv
package mrgc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_PAGE = 8'h00;
  localparam logic [7:0] A_STBY = 8'h02;
  localparam logic [7:0] A_ZTHR = 8'h3B;
  localparam logic [7:0] A_RAMP = 8'h3F;
  localparam logic [7:0] A_EMRG = 8'h40;
  localparam logic [7:0] A_ZMODE = 8'h41;
  localparam logic [7:0] A_BOOK = 8'h7F;

  localparam logic [7:0] RST_STBY = 8'h10;
  localparam logic [7:0] RST_ZTHR = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h33;
  localparam logic [7:0] RST_EMRG = 8'h00;
  localparam logic [7:0] RST_ZMODE = 8'h07;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ZM_AND_BIT = 2;
  localparam int ZM_EN_R_BIT = 1;
  localparam int ZM_EN_L_BIT = 0;
  localparam int ZT_L_LSB = 4;
  localparam int ZT_R_LSB = 0;
  localparam int UP_RATE_LSB = 6;
  localparam int UP_STEP_LSB = 4;
  localparam int DN_RATE_LSB = 2;
  localparam int DN_STEP_LSB = 0;
  localparam int EM_RATE_LSB = 6;
  localparam int EM_STEP_LSB = 4;
  localparam int STRAP_GAIN_BIT = 2;

  // ----------------------------------------
  // Tables and timing
  // ----------------------------------------
  typedef logic [18:0] mrgc_zcnt_t;
  localparam mrgc_zcnt_t ZD_THRESH [8] = '{19'h00400, 19'h01400,
    19'h02800, 19'h06400, 19'h0C800, 19'h19000, 19'h3E800, 19'h7D000};
  // Gain is attenuation in 0.5 dB units.
  localparam logic [7:0] GAIN_FULL = 8'hFF;
  localparam logic [7:0] STEP_TBL [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
  localparam logic [1:0] DIV_LAST [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
  localparam logic [1:0] RATE_DIRECT = 2'h3;
  localparam logic [3:0] MULT_TBL [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
  localparam logic [9:0] SYNC_48K_KHZ10 = 10'h3C0;
  localparam logic [9:0] SYNC_44K_KHZ10 = 10'h372;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SAMPLE_PERIOD_NS = 20833;
  localparam int INT_FRAME_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_W = 10;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [23:0] left;
    logic [23:0] right;
  } mrgc_audio_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mrgc_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
  } mrgc_strap_s;

  typedef struct packed {
    logic gain_26db;
    logic [3:0] mult;
    logic [9:0] sync_khz10;
    logic [13:0] pwm_khz10;
  } mrgc_amp_mode_s;

endpackage

// file: design/mrgc_zero_counter.sv
module mrgc_zero_counter
  import mrgc_pkg::*;
(
  input logic core_clk,
  input logic rst,
  input logic frame_tick,
  input logic smp_valid,
  input logic smp_zero,
  input logic enable,
  input logic [2:0] code,
  output logic det
);

  typedef struct packed {
    mrgc_zcnt_t cnt;
    logic zero;
    logic det;
  } mrgc_zc_state_s;

  mrgc_zc_state_s q_ff;
  mrgc_zc_state_s nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    if (!enable)
      nxt_q = '0;
    else if (smp_valid && !smp_zero)
      nxt_q = '0;
    else
    begin
      if (smp_valid)
        nxt_q.zero = 1'b1;
      if (frame_tick && (q_ff.zero || smp_valid) && !q_ff.det)
      begin
        nxt_q.cnt = q_ff.cnt + 19'h00001;
        if (nxt_q.cnt >= ZD_THRESH[code])
          nxt_q.det = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign det = q_ff.det;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_nonzero_clear: assert property (
    enable && smp_valid && !smp_zero |=> !det ##1 !det)
    else $error("Nonzero sample did not clear detection.");

  a_thresh_hit: assert property (
    enable && frame_tick && q_ff.zero && !q_ff.det && !smp_valid
    && (q_ff.cnt + 19'h00001 == ZD_THRESH[code]) |=> det)
    else $error("Zero detection missed its threshold.");

  a_det_on_count: assert property (
    $rose(det) |-> $past(q_ff.cnt) + 19'h00001 >= $past(ZD_THRESH[code]))
    else $error("Zero detection rose before the count.");

endmodule // mrgc_zero_counter

// file: design/mrgc_core.sv
module mrgc_core
  import mrgc_pkg::*;
#(
  parameter int OSC_DIV = INT_FRAME_CYC
)
(
  input logic core_clk,
  input logic rst,
  input logic word_frame_clock,
  input logic clock_fault_notice,
  input logic supply_fail,
  input logic power_stage_supply,
  input mrgc_audio_s audio,
  input logic [7:0] target_att,
  input logic rate_family_44k,
  input mrgc_strap_s strap,
  input mrgc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic play_enable,
  output logic analog_mute,
  output logic [7:0] gain_att,
  output logic use_int_osc,
  output logic hard_mute,
  output logic pwm_stop,
  output mrgc_amp_mode_s amp_mode
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Sync bits: 0 frame clock, 1 clock fault, 2 supply fail, 3 supply.
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] book;
    logic [7:0] stby;
    logic [7:0] zthr;
    logic [7:0] ramp;
    logic [7:0] emrg;
    logic [7:0] zmode;
    logic [7:0] rdata;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [OSC_W-1:0] osc;
    logic [1:0] div;
    logic [7:0] gain;
    logic play;
    logic mute;
    logic hmute;
    logic lat;
    mrgc_amp_mode_s amp;
  } mrgc_core_state_s;

  localparam mrgc_core_state_s Q_RST = '{stby: RST_STBY, zthr: RST_ZTHR,
    ramp: RST_RAMP, emrg: RST_EMRG, zmode: RST_ZMODE, gain: GAIN_FULL,
    default: '0};

  mrgc_core_state_s q_ff;
  mrgc_core_state_s nxt_q;
  logic det_l;
  logic det_r;
  logic wfc_rise;
  logic clkf;
  logic emerg;
  logic pss_fall;
  logic tick;
  logic sel;
  logic down;
  logic [7:0] tgt;
  logic [1:0] rate;
  logic [7:0] stepv;
  logic [7:0] rd;
  logic tl;
  logic tr;
  logic m;

  // ----------------------------------------
  // Zero detection per channel
  // ----------------------------------------
  mrgc_zero_counter u_zc_left (
    .core_clk(core_clk),
    .rst(rst),
    .frame_tick(wfc_rise),
    .smp_valid(audio.valid),
    .smp_zero(audio.left == 24'h000000),
    .enable(q_ff.zmode[ZM_EN_L_BIT]),
    .code(q_ff.zthr[ZT_L_LSB +: 3]),
    .det(det_l)
  );

  mrgc_zero_counter u_zc_right (
    .core_clk(core_clk),
    .rst(rst),
    .frame_tick(wfc_rise),
    .smp_valid(audio.valid),
    .smp_zero(audio.right == 24'h000000),
    .enable(q_ff.zmode[ZM_EN_R_BIT]),
    .code(q_ff.zthr[ZT_R_LSB +: 3]),
    .det(det_r)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.s1 = {power_stage_supply, supply_fail, clock_fault_notice,
      word_frame_clock};
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    wfc_rise = q_ff.s2[0] && !q_ff.s3[0];
    clkf = q_ff.s2[1];
    emerg = q_ff.s2[1] || q_ff.s2[2];
    pss_fall = !q_ff.s2[3] && q_ff.s3[3];
    sel = (q_ff.page == 8'h00) && (q_ff.book == 8'h00);

    // Register writes; data registers answer only in book 0, page 0.
    if (reg_req.wr)
    begin
      if (reg_req.addr == A_PAGE)
        nxt_q.page = reg_req.wdata;
      else if (q_ff.page == 8'h00 && reg_req.addr == A_BOOK)
        nxt_q.book = reg_req.wdata;
      else if (sel)
      begin
        case (reg_req.addr)
          A_STBY: nxt_q.stby = reg_req.wdata;
          A_ZTHR: nxt_q.zthr = reg_req.wdata;
          A_RAMP: nxt_q.ramp = reg_req.wdata;
          A_EMRG: nxt_q.emrg = reg_req.wdata;
          A_ZMODE: nxt_q.zmode = reg_req.wdata;
          default: nxt_q.page = q_ff.page;
        endcase
      end
    end

    rd = 8'h00;
    if (reg_req.addr == A_PAGE)
      rd = q_ff.page;
    else if (q_ff.page == 8'h00 && reg_req.addr == A_BOOK)
      rd = q_ff.book;
    else if (sel)
    begin
      case (reg_req.addr)
        A_STBY: rd = q_ff.stby;
        A_ZTHR: rd = q_ff.zthr;
        A_RAMP: rd = q_ff.ramp;
        A_EMRG: rd = q_ff.emrg;
        A_ZMODE: rd = q_ff.zmode;
        default: rd = 8'h00;
      endcase
    end
    if (reg_req.rd)
      nxt_q.rdata = rd;

    nxt_q.play = (q_ff.stby == 8'h00);

    tl = q_ff.zmode[ZM_EN_L_BIT] && det_l;
    tr = q_ff.zmode[ZM_EN_R_BIT] && det_r;
    if (q_ff.zmode[ZM_AND_BIT])
      m = (tl || !q_ff.zmode[ZM_EN_L_BIT])
        && (tr || !q_ff.zmode[ZM_EN_R_BIT])
        && (q_ff.zmode[ZM_EN_L_BIT] || q_ff.zmode[ZM_EN_R_BIT]);
    else
      m = tl || tr;
    nxt_q.mute = m;

    // oscillator paces frames during clock fault
    if (q_ff.osc == OSC_W'(OSC_DIV - 1))
      nxt_q.osc = '0;
    else
      nxt_q.osc = q_ff.osc + OSC_W'(1);
    tick = clkf ? (q_ff.osc == '0) : wfc_rise;

    // Volume ramp toward the effective target.
    tgt = (emerg || !q_ff.play) ? GAIN_FULL : target_att;
    down = q_ff.gain < tgt;
    if (emerg)
    begin
      rate = q_ff.emrg[EM_RATE_LSB +: 2];
      stepv = STEP_TBL[q_ff.emrg[EM_STEP_LSB +: 2]];
    end
    else if (down)
    begin
      rate = q_ff.ramp[DN_RATE_LSB +: 2];
      stepv = STEP_TBL[q_ff.ramp[DN_STEP_LSB +: 2]];
    end
    else
    begin
      rate = q_ff.ramp[UP_RATE_LSB +: 2];
      stepv = STEP_TBL[q_ff.ramp[UP_STEP_LSB +: 2]];
    end
    if (rate == RATE_DIRECT || q_ff.gain == tgt)
    begin
      nxt_q.gain = tgt;
      nxt_q.div = 2'h0;
    end
    else if (tick)
    begin
      if (q_ff.div >= DIV_LAST[rate])
      begin
        nxt_q.div = 2'h0;
        if (down)
          nxt_q.gain = (tgt - q_ff.gain <= stepv) ? tgt
            : q_ff.gain + stepv;
        else
          nxt_q.gain = (q_ff.gain - tgt <= stepv) ? tgt
            : q_ff.gain - stepv;
      end
      else
        nxt_q.div = q_ff.div + 2'h1;
    end

    nxt_q.hmute = clkf && (q_ff.hmute || q_ff.gain == GAIN_FULL);

    // latch strap once per supply cycle
    if (pss_fall)
      nxt_q.lat = 1'b0;
    else if (strap.valid && !q_ff.lat)
    begin
      nxt_q.lat = 1'b1;
      nxt_q.amp.gain_26db = strap.code[STRAP_GAIN_BIT];
      nxt_q.amp.mult = MULT_TBL[strap.code[1:0]];
    end
    nxt_q.amp.sync_khz10 = rate_family_44k ? SYNC_44K_KHZ10
      : SYNC_48K_KHZ10;
    nxt_q.amp.pwm_khz10 = 14'(q_ff.amp.mult) * 14'(q_ff.amp.sync_khz10);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q_ff <= Q_RST;
    else
      q_ff <= nxt_q;
  end

  assign reg_rdata = q_ff.rdata;
  assign play_enable = q_ff.play;
  assign analog_mute = q_ff.mute;
  assign gain_att = q_ff.gain;
  assign use_int_osc = q_ff.s2[1];
  assign hard_mute = q_ff.hmute;
  assign pwm_stop = q_ff.hmute;
  assign amp_mode = q_ff.amp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_floor;
    clkf && q_ff.gain == GAIN_FULL;
  endsequence

  sequence s_muted;
    hard_mute && pwm_stop;
  endsequence

  a_zero_and: assert property (
    q_ff.zmode[2:0] == 3'h7 |=> analog_mute == $past(det_l && det_r))
    else $error("AND combine of zero triggers wrong.");

  a_zero_or: assert property (
    q_ff.zmode[2:0] == 3'h3 |=> analog_mute == $past(det_l || det_r))
    else $error("OR combine of zero triggers wrong.");

  a_zero_off: assert property (
    q_ff.zmode[1:0] == 2'h0 |=> !analog_mute)
    else $error("Mute raised with detection disabled.");

  a_play_gate: assert property (
    q_ff.stby != 8'h00 |=> !play_enable ##1 !play_enable
      || $past(q_ff.stby) == 8'h00)
    else $error("Audio played before standby cleared.");

  a_ramp_direct: assert property (
    !emerg && rate == RATE_DIRECT |=> gain_att == $past(tgt))
    else $error("Direct gain change not applied.");

  a_ramp_step: assert property (
    !emerg && tick && rate == 2'h0 && q_ff.gain > tgt
    |=> ($past(q_ff.gain) - gain_att == $past(stepv))
      || gain_att == $past(tgt))
    else $error("Ramp-up step size wrong.");

  a_emerg_ramp: assert property (
    emerg && q_ff.emrg == RST_EMRG && tick && q_ff.gain < 8'hF0
    |=> gain_att == $past(q_ff.gain) + 8'h08)
    else $error("Emergency ramp not 4 dB per frame.");

  a_hard_mute: assert property (
    s_floor |=> s_muted)
    else $error("Hard mute missing at full attenuation.");

  a_strap_hold: assert property (
    q_ff.lat && !pss_fall |=> $stable(amp_mode.gain_26db)
      && $stable(amp_mode.mult))
    else $error("Strap mode changed without supply cycle.");

  a_strap_decode: assert property (
    strap.valid && !q_ff.lat && !pss_fall
    |=> amp_mode.gain_26db == $past(strap.code[2])
      && amp_mode.mult == MULT_TBL[$past(strap.code[1:0])])
    else $error("Strap decode wrong.");

  a_sync_rate: assert property (
    rate_family_44k |=> amp_mode.sync_khz10 == SYNC_44K_KHZ10 ##1
      amp_mode.pwm_khz10 == 14'(amp_mode.mult) * 14'(SYNC_44K_KHZ10)
      || $changed(amp_mode.mult))
    else $error("Switching rate not tied to sync rate.");

endmodule // mrgc_core

// file: dv/mrgc_audio_src.sv
module mrgc_audio_src
  import mrgc_pkg::*;
#(
  parameter int HALF = 3
)
(
  input wire logic core_clk,
  input wire logic run,
  input wire logic [23:0] l_smp,
  input wire logic [23:0] r_smp,
  output logic word_frame_clock,
  output mrgc_audio_s audio
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt = 0;

  initial word_frame_clock = 1'b0;
  initial audio = '0;

  // ----------------------------------------
  // Frame clock and samples
  // ----------------------------------------
  // one sample per frame.
  always @(posedge core_clk)
  begin
    #1;
    audio.valid = 1'b0;
    audio.left = ~audio.left;
    audio.right = ~audio.right;
    if (run)
    begin
      cnt = (cnt + 1) % (2 * HALF);
      word_frame_clock = (cnt < HALF);
      if (cnt == 1)
        audio = '{1'b1, l_smp, r_smp};
    end
  end
endmodule // mrgc_audio_src

// file: dv/tb_mute_ramp_gain_control.sv
module tb_mute_ramp_gain_control
  import mrgc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 3;
  localparam int FRAME = 2 * HALF;

  logic core_clk, rst, clock_fault_notice, supply_fail, run;
  logic power_stage_supply, rate_family_44k, word_frame_clock;
  logic [7:0] target_att, reg_rdata, gain_att, rdv;
  logic [23:0] l_smp, r_smp;
  logic play_enable, analog_mute, use_int_osc, hard_mute, pwm_stop;
  mrgc_reg_req_s reg_req;
  mrgc_strap_s strap;
  mrgc_audio_s audio;
  mrgc_amp_mode_s amp_mode;
  int errors = 0;
  int checked = 0;
  int t;
  logic [7:0] ra [5] = '{A_STBY, A_ZTHR, A_RAMP, A_EMRG, A_ZMODE};
  logic [7:0] rv [5] = '{8'h10, 8'h00, 8'h33, 8'h00, 8'h07};

  mrgc_audio_src #(.HALF(HALF)) mrgc_audio_src_inst (
    .core_clk(core_clk), .run(run), .l_smp(l_smp), .r_smp(r_smp),
    .word_frame_clock(word_frame_clock), .audio(audio));

  mrgc_core #(.OSC_DIV(4)) mrgc_core_inst (
    .core_clk(core_clk), .rst(rst), .word_frame_clock(word_frame_clock),
    .clock_fault_notice(clock_fault_notice), .supply_fail(supply_fail),
    .power_stage_supply(power_stage_supply), .audio(audio),
    .target_att(target_att), .rate_family_44k(rate_family_44k),
    .strap(strap), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .play_enable(play_enable), .analog_mute(analog_mute),
    .gain_att(gain_att), .use_int_osc(use_int_osc),
    .hard_mute(hard_mute), .pwm_stop(pwm_stop), .amp_mode(amp_mode));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic frames(input int n);
    repeat (n * FRAME) tick();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_req = '{1'b1, 1'b0, a, d};
    tick();
    reg_req = '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    tick();
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    tick();
    reg_req = '0;
    tick();
    check(reg_rdata, exp, "register read");
  endtask

  task automatic set_gain(input logic [7:0] v);
    wr(A_RAMP, 8'hFF);
    target_att = v;
    frames(2);
  endtask

  // Times two successive gain changes, skipping the partial first one.
  task automatic ramp_meas(input logic [7:0] dexp, input int cyc);
    logic [7:0] g0;
    for (int k = 0; k < 2; k++)
    begin
      g0 = gain_att;
      t = 0;
      while (gain_att === g0 && t < 3000)
      begin
        tick();
        t++;
      end
    end
    check(8'(gain_att - g0), dexp, "ramp step");
    check(t, cyc, "ramp interval");
  endtask

  task automatic sstrap(input logic [2:0] c);
    tick();
    strap = '{1'b1, c};
    tick();
    strap = '0;
    tick();
    tick();
  endtask

  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    conclude();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    clock_fault_notice = 1'b0;
    supply_fail = 1'b0;
    power_stage_supply = 1'b1;
    rate_family_44k = 1'b0;
    run = 1'b1;
    target_att = 8'h00;
    l_smp = 24'h000001;
    r_smp = 24'h000001;
    reg_req = '0;
    strap = '0;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check(play_enable, 1'b0, "play before enable");
    check(gain_att, 8'hFF, "gain at reset");
    check(amp_mode, '0, "mode at reset");
    for (int i = 0; i < 5; i++)
      rchk(ra[i], rv[i]);
    sstrap(3'h5);
    check(amp_mode, {1'b1, 4'h5, 10'h3C0, 14'(5 * 960)}, "strap 5");
    sstrap(3'h0);
    check(amp_mode, {1'b1, 4'h5, 10'h3C0, 14'(5 * 960)}, "relatch");
    power_stage_supply = 1'b0;
    frames(1);
    power_stage_supply = 1'b1;
    rate_family_44k = 1'b1;
    frames(1);
    sstrap(3'h3);
    check(amp_mode, {1'b0, 4'h8, 10'h372, 14'(8 * 882)}, "strap 3");
    rchk(8'h55, 8'h00);
    wr(A_PAGE, 8'h01);
    wr(A_ZTHR, 8'h55);
    rchk(A_ZTHR, 8'h00);
    wr(A_PAGE, 8'h00);
    rchk(A_ZTHR, 8'h00);
    wr(A_BOOK, 8'h00);
    tick();
    check(play_enable, 1'b0, "play before standby write");
    wr(A_STBY, 8'h00);
    tick();
    check(play_enable, 1'b1, "play after enable");
    for (int i = 0; i < 4; i++)
    begin
      logic [1:0] r;
      r = (i == 3) ? 2'h0 : i[1:0];
      set_gain(8'h00);
      wr(A_RAMP, {2'h3, 2'h3, r, i[1:0]});
      target_att = 8'hFF;
      ramp_meas(8'h08 >> i, FRAME << r);
      set_gain(8'hFF);
      wr(A_RAMP, {r, i[1:0], 2'h3, 2'h3});
      target_att = 8'h00;
      ramp_meas(8'h00 - (8'h08 >> i), FRAME << r);
    end
    set_gain(8'h00);
    target_att = 8'h5A;
    repeat (3) tick();
    check(gain_att, 8'h5A, "direct change");
    set_gain(8'h00);
    supply_fail = 1'b1;
    ramp_meas(8'h08, FRAME);
    supply_fail = 1'b0;
    set_gain(8'h00);
    wr(A_EMRG, 8'h50);
    supply_fail = 1'b1;
    ramp_meas(8'h04, 2 * FRAME);
    supply_fail = 1'b0;
    set_gain(8'h00);
    clock_fault_notice = 1'b1;
    run = 1'b0;
    repeat (4) tick();
    check(use_int_osc, 1'b1, "internal oscillator");
    ramp_meas(8'h04, 8);
    check(hard_mute, 1'b0, "early hard mute");
    t = 0;
    while (hard_mute !== 1'b1 && t < 3000)
    begin
      tick();
      t++;
    end
    check(gain_att, 8'hFF, "mute after ramp");
    check(pwm_stop, 1'b1, "pwm stopped");
    clock_fault_notice = 1'b0;
    run = 1'b1;
    repeat (5) tick();
    check({hard_mute, use_int_osc}, 2'b00, "fault cleared");
    l_smp = 24'h000000;
    r_smp = 24'h000000;
    frames(1000);
    check(analog_mute, 1'b0, "and early");
    frames(40);
    check(analog_mute, 1'b1, "and mute");
    r_smp = 24'h800000;
    frames(3);
    check(analog_mute, 1'b0, "nonzero release");
    l_smp = 24'h000010;
    wr(A_ZMODE, 8'h03);
    frames(3);
    l_smp = 24'h000000;
    frames(1000);
    check(analog_mute, 1'b0, "or early");
    frames(40);
    check(analog_mute, 1'b1, "or mute");
    l_smp = 24'h000010;
    wr(A_ZMODE, 8'h02);
    wr(A_ZTHR, 8'h01);
    frames(3);
    check(analog_mute, 1'b0, "left cleared");
    l_smp = 24'h000000;
    r_smp = 24'h000000;
    frames(5100);
    check(analog_mute, 1'b0, "left disabled");
    frames(40);
    check(analog_mute, 1'b1, "right code 1");
    wr(A_ZMODE, 8'h04);
    frames(2);
    check(analog_mute, 1'b0, "none enabled");
    conclude();
  end
endmodule // tb_mute_ramp_gain_control
